// ==== lasm_alert.sv ====
// sticky limit flags, alert masks and the alert pin of the monitor
// assumes the bus engine on i_link_clk presents one byte access at a time
// and the limit comparators deliver conditions on i_ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "lasm_cfg.svh"

module lasm_alert
   import lasm_pkg::*;
(
   // clocks and reset
   input wire logic i_ref_clk,
   input wire logic i_link_clk,
   input wire logic i_rst_n,
   // out-of-limit conditions from the comparators
   input wire logic i_remote_two_temp_ool,
   input wire logic i_local_temp_ool,
   input wire logic i_remote_one_temp_ool,
   input wire logic i_main_supply_ool,
   input wire logic i_core_supply_ool,
   input wire logic i_diode_two_fault,
   input wire logic i_diode_one_fault,
   input wire logic i_fourth_fan_slow,
   input wire logic i_timer_over,
   input wire logic i_third_fan_slow,
   input wire logic i_second_fan_slow,
   input wire logic i_first_fan_slow,
   input wire logic i_overtemp,
   // register access from the serial bus engine
   input wire logic i_link_req,
   input wire logic i_link_wr,
   input wire logic [7:0] i_link_addr,
   input wire logic [7:0] i_link_wdata,
   output logic o_link_busy,
   output logic o_link_done,
   output logic [7:0] o_link_rdata,
   // open-drain alert pin, active low on the wire
   output logic o_alert_o,
   output logic o_alert_oe
);

   lasm_core_t c_r;
   lasm_core_t c_nxt;
   lasm_link_t l_r;
   lasm_link_t l_nxt;

   logic req_ev;
   logic ack_ev;
   logic rd1;
   logic rd2;
   logic fourth_src;
   logic pin_thermal;
   logic pend1;
   logic pend2;
   logic [7:0] cond1;
   logic [7:0] cond2;
   logic [7:0] eff1;
   logic [7:0] s1_view;

   // reference clock side

   always_comb begin
      c_nxt = c_r;
      c_nxt.req_sync = {c_r.req_sync[`LASM_SYNC_STAGES-2:0], l_r.req_tgl};
      // a toggle counts once the second and third stages agree
      req_ev = (c_r.req_sync[1] == c_r.req_sync[2]) &&
               (c_r.req_sync[2] != c_r.req_seen);
      if (req_ev) begin
         c_nxt.req_seen = c_r.req_sync[2];
      end
      rd1 = req_ev && !l_r.wr && (l_r.addr == `LASM_OFS_STAT1);
      rd2 = req_ev && !l_r.wr && (l_r.addr == `LASM_OFS_STAT2);

      pin_thermal = (c_r.pin9_func == `LASM_PIN9_THERMAL);
      // one status bit shared by fan 4 and the thermal timer
      fourth_src = pin_thermal ? i_timer_over
                               : i_fourth_fan_slow;

      cond1 = `LASM_RST_BYTE;
      cond1[`LASM_BIT_R2T] = i_remote_two_temp_ool;
      cond1[`LASM_BIT_LT] = i_local_temp_ool;
      cond1[`LASM_BIT_R1T] = i_remote_one_temp_ool;
      cond1[`LASM_BIT_MAIN] = i_main_supply_ool;
      cond1[`LASM_BIT_CORE] = i_core_supply_ool;

      cond2 = `LASM_RST_BYTE;
      cond2[`LASM_BIT_D2] = i_diode_two_fault;
      cond2[`LASM_BIT_D1] = i_diode_one_fault;
      cond2[`LASM_BIT_F4] = fourth_src;
      cond2[`LASM_BIT_THIRD_FAN_FLAG] = i_third_fan_slow;
      cond2[`LASM_BIT_SECOND_FAN_FLAG] = i_second_fan_slow;
      cond2[`LASM_BIT_FIRST_FAN_FLAG] = i_first_fan_slow;
      cond2[`LASM_BIT_OVT] = i_overtemp;

      // set wins over the read clear, so a live condition keeps its flag
      c_nxt.stat1 = cond1 |
         (c_r.stat1 & ~{8{rd1}});
      c_nxt.stat2 = cond2 |
         (c_r.stat2 & ~{8{rd2}});

      // summary bit is derived live, never stored
      s1_view = c_r.stat1 & `LASM_STAT1_USED;
      s1_view[`LASM_BIT_SUMMARY] =
         |(c_r.stat2 & `LASM_STAT2_USED);

      if (req_ev) begin
         c_nxt.ack_tgl = ~c_r.ack_tgl;
         c_nxt.rdata = `LASM_RST_BYTE;
         if (l_r.wr) begin
            unique case (l_r.addr)
               `LASM_OFS_MASK1: begin
                  c_nxt.mask1 = l_r.wdata & `LASM_MASK1_USED;
               end
               `LASM_OFS_MASK2: begin
                  c_nxt.mask2 = l_r.wdata & `LASM_MASK2_USED;
               end
               `LASM_OFS_CFG3: begin
                  c_nxt.alert_en =
                     l_r.wdata[`LASM_BIT_ALERT_EN];
               end
               `LASM_OFS_CFG4: begin
                  c_nxt.pin9_func = l_r.wdata[1:0];
               end
               default: begin
                  c_nxt.mask1 = c_r.mask1;
               end
            endcase
         end else begin
            unique case (l_r.addr)
               `LASM_OFS_STAT1: begin
                  c_nxt.rdata = s1_view;
               end
               `LASM_OFS_STAT2: begin
                  c_nxt.rdata = c_r.stat2 & `LASM_STAT2_USED;
               end
               `LASM_OFS_MASK1: begin
                  c_nxt.rdata = c_r.mask1;
               end
               `LASM_OFS_MASK2: begin
                  c_nxt.rdata = c_r.mask2;
               end
               `LASM_OFS_CFG3: begin
                  c_nxt.rdata = {7'h00, c_r.alert_en};
               end
               `LASM_OFS_CFG4: begin
                  c_nxt.rdata = {6'h00, c_r.pin9_func};
               end
               default: begin
                  c_nxt.rdata = `LASM_RST_BYTE;
               end
            endcase
         end
      end

      // core supply is masked by bit 0, so remap the mask onto flag bits
      eff1 = `LASM_RST_BYTE;
      eff1[`LASM_BIT_R2T] = c_r.mask1[`LASM_BIT_R2T];
      eff1[`LASM_BIT_LT] = c_r.mask1[`LASM_BIT_LT];
      eff1[`LASM_BIT_R1T] = c_r.mask1[`LASM_BIT_R1T];
      eff1[`LASM_BIT_MAIN] = c_r.mask1[`LASM_BIT_MAIN];
      eff1[`LASM_BIT_CORE] = c_r.mask1[`LASM_BIT_CORE_MASK];

      // live conditions are or-ed in so the alert does not lag a cycle
      pend1 = |((c_r.stat1 | cond1) & ~eff1 &
                `LASM_STAT1_USED);
      pend2 = |((c_r.stat2 | cond2) & ~c_r.mask2 &
                `LASM_STAT2_USED)
              && !c_r.mask1[`LASM_BIT_SUMMARY];
      // mask-2 bits 7..1 in the term above

      c_nxt.alert_o = 1'b0;
      c_nxt.alert_oe = (c_r.alert_en ||
         (c_r.pin9_func == `LASM_PIN9_ALERT)) &&
         (pend1 || pend2);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   // link clock side

   always_comb begin
      l_nxt = l_r;
      l_nxt.done = 1'b0;
      l_nxt.ack_sync = {l_r.ack_sync[`LASM_SYNC_STAGES-2:0], c_r.ack_tgl};
      ack_ev = (l_r.ack_sync[1] == l_r.ack_sync[2]) &&
               (l_r.ack_sync[2] != l_r.ack_seen);
      if (ack_ev) begin
         // rdata was registered in the same cycle as the ack toggle on the core side
         l_nxt.ack_seen = l_r.ack_sync[2];
         l_nxt.busy = 1'b0;
         l_nxt.done = 1'b1;
         l_nxt.rdata = c_r.rdata;
      end else if (i_link_req && !l_r.busy) begin
         // fields stay frozen until the ack, the core samples them late
         l_nxt.wr = i_link_wr;
         l_nxt.addr = i_link_addr;
         l_nxt.wdata = i_link_wdata;
         l_nxt.req_tgl = ~l_r.req_tgl;
         l_nxt.busy = 1'b1;
      end
   end

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   assign o_link_busy = l_r.busy;
   assign o_link_done = l_r.done;
   assign o_link_rdata = l_r.rdata;
   assign o_alert_o = c_r.alert_o;
   assign o_alert_oe = c_r.alert_oe;

   // checks on the reference clock

   chk_summary_read: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      rd1 |=> c_r.rdata[`LASM_BIT_SUMMARY] == (|$past(c_r.stat2)))
      else $error("summary bit does not follow status-2");

   chk_temp_capture: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_local_temp_ool |=> c_r.stat1[`LASM_BIT_LT])
      else $error("local temperature flag not set");

   chk_core_supply: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_core_supply_ool |=> c_r.stat1[`LASM_BIT_CORE])
      else $error("core supply flag not set");

   chk_diode_fault: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_diode_two_fault |=> c_r.stat2[`LASM_BIT_D2])
      else $error("diode-2 fault flag not set");

   chk_fourth_select: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (pin_thermal && i_timer_over) |=> c_r.stat2[`LASM_BIT_F4])
      else $error("timer event not flagged in thermal mode");

   chk_flag_sticky: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.stat2[`LASM_BIT_FIRST_FAN_FLAG] && !rd2) |=> c_r.stat2[`LASM_BIT_FIRST_FAN_FLAG])
      else $error("fan-1 flag dropped without a read");

   chk_alert_held: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.alert_en && i_overtemp && !c_r.mask2[`LASM_BIT_OVT] &&
       !c_r.mask1[`LASM_BIT_SUMMARY]) |=> c_r.alert_oe)
      else $error("alert not driven for unmasked overtemperature");

   chk_alert_gated: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      c_r.alert_oe |-> ($past(c_r.alert_en) ||
         ($past(c_r.pin9_func) == `LASM_PIN9_ALERT)))
      else $error("alert driven while the pin is unassigned");

   chk_reserved_zero: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.stat1[3] == 1'b0) && (c_r.stat2[0] == 1'b0) &&
      (c_r.mask1[3] == 1'b0) && (c_r.mask1[1] == 1'b0))
      else $error("unassigned bit became set");

   chk_remote_capture: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_remote_two_temp_ool |=> c_r.stat1[`LASM_BIT_R2T])
      else $error("remote-2 temperature flag not set");

   chk_main_capture: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_main_supply_ool |=> c_r.stat1[`LASM_BIT_MAIN])
      else $error("main supply flag not set");

   chk_fan_capture: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_third_fan_slow |=> c_r.stat2[`LASM_BIT_THIRD_FAN_FLAG])
      else $error("fan-3 flag not set");

   chk_overtemp_flag: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_overtemp |=> c_r.stat2[`LASM_BIT_OVT])
      else $error("overtemperature flag not set");

   chk_fourth_fan: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!pin_thermal && i_fourth_fan_slow) |=> c_r.stat2[`LASM_BIT_F4])
      else $error("fan-4 flag not set outside thermal mode");

   chk_masked_capture: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_diode_one_fault && c_r.mask2[`LASM_BIT_D1]) |=>
         c_r.stat2[`LASM_BIT_D1])
      else $error("masked diode-1 fault not flagged");

   chk_read_clear: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (rd2 && !i_first_fan_slow) |=> !c_r.stat2[`LASM_BIT_FIRST_FAN_FLAG])
      else $error("fan-1 flag kept after read with fault gone");

   chk_group_blocked: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.mask1[`LASM_BIT_SUMMARY] && (c_r.stat1 == 8'h00) &&
       !i_remote_two_temp_ool && !i_local_temp_ool &&
       !i_remote_one_temp_ool && !i_main_supply_ool &&
       !i_core_supply_ool) |=> !c_r.alert_oe)
      else $error("status-2 source drove the alert while blocked");

   chk_core_unmasked: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.alert_en && i_core_supply_ool &&
       !c_r.mask1[`LASM_BIT_CORE_MASK]) |=> c_r.alert_oe)
      else $error("alert not driven for unmasked core supply");

   chk_local_unmasked: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.alert_en && i_local_temp_ool && !c_r.mask1[`LASM_BIT_LT]) |=>
         c_r.alert_oe)
      else $error("alert not driven for unmasked local temperature");

   chk_diode_unmasked: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.alert_en && i_diode_two_fault && !c_r.mask2[`LASM_BIT_D2] &&
       !c_r.mask1[`LASM_BIT_SUMMARY]) |=> c_r.alert_oe)
      else $error("alert not driven for unmasked diode-2 fault");

   chk_fan_unmasked: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.alert_en && i_second_fan_slow && !c_r.mask2[`LASM_BIT_SECOND_FAN_FLAG] &&
       !c_r.mask1[`LASM_BIT_SUMMARY]) |=> c_r.alert_oe)
      else $error("alert not driven for unmasked fan-2");

   chk_timer_unmasked: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (c_r.alert_en && pin_thermal && i_timer_over &&
       !c_r.mask2[`LASM_BIT_F4] && !c_r.mask1[`LASM_BIT_SUMMARY]) |=>
         c_r.alert_oe)
      else $error("alert not driven for unmasked timer event");

   chk_enable_write: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (req_ev && l_r.wr && (l_r.addr == `LASM_OFS_CFG3) &&
       l_r.wdata[`LASM_BIT_ALERT_EN]) |=> c_r.alert_en)
      else $error("alert enable write not taken");

   chk_mask_readback: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (req_ev && !l_r.wr && (l_r.addr == `LASM_OFS_MASK2)) |=>
         (c_r.rdata == $past(c_r.mask2)))
      else $error("mask-2 read returned a wrong value");

endmodule
`default_nettype wire

// ==== lasm_cfg.svh ====
// constants for the limit alert status and mask block
// assumes it is included by bare name from the package and the design
//
// Behaviour
// - status-1 bit 7 is set whenever any status-2 flag is set
// - status-1 bits 6,5,4 flag remote-2, local, remote-1 temperature
// - status-1 bit 2 flags main supply, bit 1 core supply
// - status-2 bit 7 flags diode-2 fault, bit 6 diode-1 fault
// - status-2 bit 5 flags fourth fan slow, or timer over in thermal mode
// - status-2 bits 4,3,2 flag fans 3,2,1 below minimum speed
// - status-2 bit 1 flags any thermal overtemperature limit exceeded
// - a flag sets as soon as its channel reports out of limit
// - a flag clears only after condition gone and register read
// - alert stays low while unmasked condition lasts and until read
// - mask bits gate only the alert, flags still set normally
// - mask-1 bit 7 blocks alert from every status-2 flag
// - mask-1 bits 6,5,4 block remote-2, local, remote-1 temperature
// - mask-1 bit 2 blocks main supply, bit 0 blocks core supply
// - mask-2 bits 7,6 block diode-2 and diode-1 faults
// - mask-2 bit 5 blocks fourth fan or thermal timer event
// - mask-2 bits 4,3,2 block fan 3, fan 2, fan 1
// - mask-2 bit 1 blocks the overtemperature flag
// - alert output disabled after reset until a pin is configured
// - config-3 bit 0 routes the alert onto the first pin
// - host reaches status and mask registers over the serial bus
`ifndef LASM_CFG_SVH
`define LASM_CFG_SVH

`define LASM_OFS_STAT1 8'h41
`define LASM_OFS_STAT2 8'h42
`define LASM_OFS_MASK1 8'h74
`define LASM_OFS_MASK2 8'h75
`define LASM_OFS_CFG3 8'h78
`define LASM_OFS_CFG4 8'h7d

`define LASM_STAT1_USED 8'h76
`define LASM_STAT2_USED 8'hfe
`define LASM_MASK1_USED 8'hf5
`define LASM_MASK2_USED 8'hfe

`define LASM_BIT_SUMMARY 7
`define LASM_BIT_R2T 6
`define LASM_BIT_LT 5
`define LASM_BIT_R1T 4
`define LASM_BIT_MAIN 2
`define LASM_BIT_CORE 1
`define LASM_BIT_CORE_MASK 0
`define LASM_BIT_D2 7
`define LASM_BIT_D1 6
`define LASM_BIT_F4 5
`define LASM_BIT_THIRD_FAN_FLAG 4
`define LASM_BIT_SECOND_FAN_FLAG 3
`define LASM_BIT_FIRST_FAN_FLAG 2
`define LASM_BIT_OVT 1
`define LASM_BIT_ALERT_EN 0

`define LASM_PIN9_THERMAL 2'h1
`define LASM_PIN9_ALERT 2'h2

`define LASM_RST_BYTE 8'h00
`define LASM_SYNC_STAGES 3

`endif

// ==== lasm_host_model.sv ====
// bus engine model that issues single byte accesses to the alert block
// assumes the block answers each accepted request with a done pulse
`timescale 1ns/1ns
`default_nettype none

module lasm_host_model (
   // answer from the block
   input wire logic i_link_clk,
   input wire logic i_link_busy,
   input wire logic i_link_done,
   input wire logic [7:0] i_link_rdata,
   // request to the block
   output logic o_link_req,
   output logic o_link_wr,
   output logic [7:0] o_link_addr,
   output logic [7:0] o_link_wdata
);
   initial begin
      o_link_req = 1'b0;
      o_link_wr = 1'b0;
      o_link_addr = 8'h00;
      o_link_wdata = 8'h00;
   end

   // one access, held until done
   task automatic access(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      q = 8'h00;
      @(posedge i_link_clk) #1;
      while (i_link_busy !== 1'b0 && n < 40) begin
         @(posedge i_link_clk) #1;
         n++;
      end
      o_link_req = 1'b1;
      o_link_wr = w;
      o_link_addr = a;
      o_link_wdata = d;
      while (!ok && n < 80) begin
         @(posedge i_link_clk) #1;
         n++;
         if (i_link_done === 1'b1) begin
            ok = 1'b1;
            q = i_link_rdata;
         end
      end
      // released fields show junk so a stale value is never trusted
      o_link_req = 1'b0;
      o_link_wr = ~w;
      o_link_addr = ~a;
      o_link_wdata = ~d;
   endtask
endmodule

`default_nettype wire

// ==== lasm_pkg.sv ====
// types for the limit alert status and mask block
// assumes lasm_cfg.svh sits in the same folder
`default_nettype none
`include "lasm_cfg.svh"

package lasm_pkg;

   // state on the reference clock
   typedef struct packed {
      logic [7:0] stat1;
      logic [7:0] stat2;
      logic [7:0] mask1;
      logic [7:0] mask2;
      logic alert_en;
      logic [1:0] pin9_func;
      logic [`LASM_SYNC_STAGES-1:0] req_sync;
      logic req_seen;
      logic ack_tgl;
      logic [7:0] rdata;
      logic alert_oe;
      logic alert_o;
   } lasm_core_t;

   // state on the link clock
   typedef struct packed {
      logic req_tgl;
      logic busy;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [`LASM_SYNC_STAGES-1:0] ack_sync;
      logic ack_seen;
      logic [7:0] rdata;
      logic done;
   } lasm_link_t;

endpackage

`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the limit alert status and mask block
// assumes the host model sits on the link side of the block
`timescale 1ns/1ns
`default_nettype none

module testbench;
   localparam int SB[13] = '{6, 5, 4, 2, 1, 7, 6, 5, 4, 3, 2, 1, 5};
   localparam int MB[13] = '{6, 5, 4, 2, 0, 7, 6, 5, 4, 3, 2, 1, 5};
   logic i_ref_clk, i_link_clk, i_rst_n;
   logic [12:0] cond;
   logic req, wr, busy, done, alert_o, alert_oe;
   logic [7:0] addr, wdata, rdata;
   int n_mismatch = 0;
   int total_checks = 0;

   lasm_alert dut (.i_ref_clk(i_ref_clk), .i_link_clk(i_link_clk),
      .i_rst_n(i_rst_n), .i_remote_two_temp_ool(cond[0]),
      .i_local_temp_ool(cond[1]), .i_remote_one_temp_ool(cond[2]),
      .i_main_supply_ool(cond[3]), .i_core_supply_ool(cond[4]),
      .i_diode_two_fault(cond[5]), .i_diode_one_fault(cond[6]),
      .i_fourth_fan_slow(cond[7]), .i_third_fan_slow(cond[8]),
      .i_second_fan_slow(cond[9]), .i_first_fan_slow(cond[10]),
      .i_overtemp(cond[11]), .i_timer_over(cond[12]),
      .i_link_req(req), .i_link_wr(wr), .i_link_addr(addr),
      .i_link_wdata(wdata), .o_link_busy(busy), .o_link_done(done),
      .o_link_rdata(rdata), .o_alert_o(alert_o), .o_alert_oe(alert_oe));

   lasm_host_model host (.i_link_clk(i_link_clk), .i_link_busy(busy),
      .i_link_done(done), .i_link_rdata(rdata), .o_link_req(req),
      .o_link_wr(wr), .o_link_addr(addr), .o_link_wdata(wdata));

   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #2;
      forever #3 i_link_clk = ~i_link_clk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] e,
      input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask

   task automatic acc(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      logic ok;
      host.access(w, a, d, q, ok);
      chk("access done", 8'h01, {7'h00, ok});
      chk("link busy", 8'h00, {7'h00, busy});
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      acc(1'b0, a, 8'h00, q);
      chk($sformatf("register %h", a), e, q);
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(1'b1, a, d, q);
   endtask

   // oe high means the wire is pulled low; the driven level stays 0
   task automatic pin(input logic e);
      chk("alert pin", {6'h00, e, 1'b0},
         {6'h00, alert_oe, alert_o});
   endtask

   // one source: raise, read while live, drop, read until cleared
   task automatic run(input int i, input logic m);
      logic [7:0] sa, sx, ma;
      sa = (i < 5) ? 8'h41 : 8'h42;
      sx = 8'h01 << SB[i];
      ma = (i < 5 || i == 11) ? 8'h74 : 8'h75;
      if (i == 12) wreg(8'h7d, 8'h01);
      if (m) wreg(ma, (i == 11) ? 8'h80 : 8'h01 << MB[i]);
      cond[i] = 1'b1;
      cyc(3);
      pin(!m);
      if (i > 4) rd(8'h41, 8'h80);
      rd(sa, sx);
      rd(sa, sx);
      cond[i] = 1'b0;
      cyc(3);
      pin(!m);
      rd(sa, sx);
      rd(sa, 8'h00);
      if (i > 4) rd(8'h41, 8'h00);
      pin(1'b0);
      if (m) wreg(ma, 8'h00);
      if (i == 12) wreg(8'h7d, 8'h00);
   endtask

   // a few accesses per source at about 100 ns each: far below this
   initial begin
      #500000;
      n_mismatch++;
      stop_test();
   end

   initial begin
      i_rst_n = 1'b0;
      cond = 13'h0000;
      cyc(3);
      i_rst_n = 1'b1;
      cyc(2);
      pin(1'b0);
      rd(8'h41, 8'h00);
      rd(8'h42, 8'h00);
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h00);
      wreg(8'h74, 8'hff);
      rd(8'h74, 8'hf5);
      wreg(8'h75, 8'hff);
      rd(8'h75, 8'hfe);
      wreg(8'h43, 8'hff);
      rd(8'h43, 8'h00);
      wreg(8'h74, 8'h00);
      wreg(8'h75, 8'h00);
      cond[3] = 1'b1;
      cyc(3);
      pin(1'b0);
      wreg(8'h7d, 8'h02);
      cyc(2);
      pin(1'b1);
      wreg(8'h7d, 8'h00);
      cyc(2);
      pin(1'b0);
      wreg(8'h78, 8'h01);
      cyc(2);
      pin(1'b1);
      cond[3] = 1'b0;
      rd(8'h41, 8'h04);
      rd(8'h41, 8'h00);
      for (int i = 0; i < 13; i++) begin
         run(i, 1'b0);
         run(i, 1'b1);
      end
      // overtemperature blocked by its own mask-2 bit, not the group bit
      wreg(8'h75, 8'h02);
      cond[11] = 1'b1;
      cyc(3);
      pin(1'b0);
      rd(8'h42, 8'h02);
      cond[11] = 1'b0;
      rd(8'h42, 8'h02);
      rd(8'h42, 8'h00);
      wreg(8'h75, 8'h00);
      stop_test();
   end
endmodule

`default_nettype wire
